/* File: verilog/ivp_pkg.sv */
// shared constants for the interrupt vector placement block
package ivp_pkg;
   // program word address width
   localparam int PC_W = 14;
   // number of interrupt sources, reset excluded
   localparam int NUM_IRQ = 25;
   // irq index width
   localparam int IRQ_W = 5;
   // register bus widths
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   // control register offset on the local bus
   localparam logic [ADDR_W-1:0] MCU_CONTROL_OFS = 8'h00;
   // control register field positions
   localparam int UNLOCK_BIT = 0;
   localparam int VSEL_BIT = 1;
   localparam int PUD_BIT = 4;
   // control register reset value
   localparam logic [DATA_W-1:0] MCU_CONTROL_RST = 8'h00;
   // readable bits of the control register
   localparam logic [DATA_W-1:0] MCU_CONTROL_RMASK = 8'h13;
   // reset vector and first interrupt vector offset
   localparam logic [PC_W-1:0] RESET_VEC = 14'h0000;
   localparam logic [PC_W-1:0] FIRST_VEC = 14'h0002;
   // vector spacing in words
   localparam logic [PC_W-1:0] VEC_STEP = 14'h0002;
   // last vector offset, store-program-memory ready
   localparam logic [PC_W-1:0] LAST_VEC = 14'h0032;
   // cycles the unlock window stays open
   localparam logic [2:0] UNLOCK_CYCLES = 3'h4;
   // a fuse reads 0 when programmed
   localparam logic FUSE_PROGRAMMED = 1'b0;
   // boot section start per boot size fuse code, word addresses
   localparam logic [PC_W-1:0] BOOT_START_SZ0 = 14'h1800;
   localparam logic [PC_W-1:0] BOOT_START_SZ1 = 14'h1c00;
   localparam logic [PC_W-1:0] BOOT_START_SZ2 = 14'h1e00;
   localparam logic [PC_W-1:0] BOOT_START_SZ3 = 14'h1f00;
   // irq source indices, vector number minus two
   localparam logic [IRQ_W-1:0] IRQ_EXT_REQUEST_ZERO = 5'h00;
   localparam logic [IRQ_W-1:0] IRQ_WATCHDOG_TIMEOUT = 5'h05;
   localparam logic [IRQ_W-1:0] IRQ_TIMER1_OVF = 5'h0c;
   localparam logic [IRQ_W-1:0] IRQ_TIMER0_COMPA = 5'h0d;
   localparam logic [IRQ_W-1:0] IRQ_SELF_PROGRAM_READY = 5'h18;
endpackage

/* File: verilog/interrupt_vector_placement.sv */
// interrupt vector placement: vector addresses, table select, unlock sequence
//
// The implementer's own choices: the register offsets and strobed register access.
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// What this block does
// - reset vector at zero while the reset fuse is unprogrammed
// - vectors two words apart from 0x0002
// - spacing continues from 0x001c to 0x0032
// - programmed reset fuse starts at boot address
// - select clear puts table at flash start
// - select set adds boot start to vector
// - boot start comes from boot size fuses
// - reset and vector bases combine both settings
// - fuse 1 unprogrammed, 0 programmed
// - select changes only within four-cycle unlock window
// - mask from unlock until after following instruction
// - unused unlock masks interrupts for five cycles: the unlock cycle and the four-cycle window
// - masking leaves global enable flag untouched
// - unlock clears after four cycles or select write
// - boot table, app lock blocks app-side interrupts
// - app table, boot lock blocks boot-side interrupts
// - control bits 0,1,4; others zero; reset zero
// - small variant has no table select bit
// - pull-up disable bit turns off all pull-ups
module interrupt_vector_placement #(
   parameter bit HAS_VECTOR_SELECT = 1'b1 // 0 for the smallest variant
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // register port
   input wire logic [ivp_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [ivp_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [ivp_pkg::DATA_W-1:0] reg_rdata,
   // fuses and lock bits, static pins
   input wire logic boot_reset_fuse,
   input wire logic [1:0] boot_size_fuses,
   input wire logic app_lock_bit,
   input wire logic boot_lock_bit,
   // core status
   input wire logic global_int_enable,
   input wire logic exec_in_boot,
   input wire logic instr_retire,
   // interrupt sources, index 0 is vector 2
   input wire logic [ivp_pkg::NUM_IRQ-1:0] irq_req,
   // vector outputs to the core
   output logic [ivp_pkg::PC_W-1:0] reset_vector_addr,
   output logic irq_valid,
   output logic [ivp_pkg::IRQ_W-1:0] irq_index,
   output logic [ivp_pkg::PC_W-1:0] irq_vector_addr,
   output logic irq_masked,
   // control register fields
   output logic vector_table_select,
   output logic pullup_global_disable
);
   import ivp_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers for the fuse and lock straps

   // first stage, read only by the second stage
   logic [4:0] fuse_meta_r;
   // second stage, safe to use
   logic [4:0] fuse_sync_r;

   // reset to unprogrammed, so no strap can move a vector before it is synchronised
   // two flops per strap bit; straps are static but come from outside
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         fuse_meta_r <= 5'h1f;
         fuse_sync_r <= 5'h1f;
      end else begin
         fuse_meta_r <= {boot_lock_bit, app_lock_bit, boot_size_fuses, boot_reset_fuse};
         fuse_sync_r <= fuse_meta_r;
      end
   end

   // named views of the synchronised straps
   // bit order matches the concatenation in the synchroniser above
   logic boot_reset_fuse_s;
   logic [1:0] boot_size_s;
   logic app_lock_s;
   logic boot_lock_s;
   assign boot_reset_fuse_s = fuse_sync_r[0];
   assign boot_size_s = fuse_sync_r[2:1];
   assign app_lock_s = fuse_sync_r[3];
   assign boot_lock_s = fuse_sync_r[4];

   ////////////////////////////////////////////////////////////////////////////
   // boot section start and reset vector

   // boot section start in words
   logic [PC_W-1:0] boot_start;

   // decode the boot size fuses
   // the straps only change at power-up, so a plain decode is enough
   always_comb begin
      case (boot_size_s)
         2'h0: boot_start = BOOT_START_SZ0;
         2'h1: boot_start = BOOT_START_SZ1;
         2'h2: boot_start = BOOT_START_SZ2;
         default: boot_start = BOOT_START_SZ3;
      endcase
   end

   // reset fetch address; programmed fuse reads as zero
   // limitation: valid only from the third edge after reset, once the straps are through
   logic [PC_W-1:0] reset_vector_r;
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         reset_vector_r <= RESET_VEC;
      end else if (boot_reset_fuse_s == FUSE_PROGRAMMED) begin
         reset_vector_r <= boot_start;
      end else begin
         reset_vector_r <= RESET_VEC;
      end
   end
   assign reset_vector_addr = reset_vector_r;

   ////////////////////////////////////////////////////////////////////////////
   // control register and unlock sequence

   // decoded accesses
   logic wr_hit;
   logic rd_hit;
   assign wr_hit = reg_wr && (reg_addr == MCU_CONTROL_OFS);
   assign rd_hit = reg_rd && (reg_addr == MCU_CONTROL_OFS);

   // unlock write and select write in this cycle
   logic unlock_wr;
   logic vsel_wr;
   // unlock window countdown; nonzero means the change bit reads one
   logic [2:0] unlock_cnt_r;
   logic [2:0] unlock_cnt_nxt;
   logic window_open;
   // the change bit is not stored: it reads as the window itself
   assign window_open = (unlock_cnt_r != 3'h0);
   assign unlock_wr = wr_hit && reg_wdata[UNLOCK_BIT];
   // select only taken inside the window, change bit written zero
   assign vsel_wr = wr_hit && !reg_wdata[UNLOCK_BIT] && window_open;

   // countdown next value
   // an unlock inside the window restarts it rather than taking the select bit
   always_comb begin
      if (unlock_wr) begin
         unlock_cnt_nxt = UNLOCK_CYCLES; // restart window
      end else if (vsel_wr) begin
         unlock_cnt_nxt = 3'h0;
      end else if (window_open) begin
         unlock_cnt_nxt = unlock_cnt_r - 3'h1;
      end else begin
         unlock_cnt_nxt = 3'h0;
      end
   end

   // unlock counter
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         unlock_cnt_r <= 3'h0;
      end else begin
         unlock_cnt_r <= unlock_cnt_nxt;
      end
   end

   // table select bit; absent on the small variant
   logic vsel_r;
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         vsel_r <= MCU_CONTROL_RST[VSEL_BIT];
      end else if (HAS_VECTOR_SELECT && vsel_wr) begin
         vsel_r <= reg_wdata[VSEL_BIT];
      end
   end
   assign vector_table_select = vsel_r;

   // pull-up disable, plain read/write
   // every write reloads it, even one that only tries to move the table
   logic pud_r;
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         pud_r <= MCU_CONTROL_RST[PUD_BIT];
      end else if (wr_hit) begin
         pud_r <= reg_wdata[PUD_BIT];
      end
   end
   assign pullup_global_disable = pud_r;

   // read image; unused bits read zero
   logic [DATA_W-1:0] ctrl_image;
   always_comb begin
      ctrl_image = MCU_CONTROL_RST;
      ctrl_image[UNLOCK_BIT] = window_open;
      ctrl_image[VSEL_BIT] = vsel_r;
      ctrl_image[PUD_BIT] = pud_r;
      ctrl_image = ctrl_image & MCU_CONTROL_RMASK;
   end

   // read data one cycle after the strobe; unmapped reads give zero
   // zero outside the read cycle, so several slaves can simply be or-ed together
   logic [DATA_W-1:0] rdata_r;
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_r <= 8'h00;
      end else if (rd_hit) begin
         rdata_r <= ctrl_image;
      end else begin
         rdata_r <= 8'h00;
      end
   end
   assign reg_rdata = rdata_r;

   ////////////////////////////////////////////////////////////////////////////
   // automatic masking during the change sequence

   // hold after a select write until the next instruction retires
   // a select write in a retire cycle still sets the hold: the set wins
   logic post_hold_r;
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         post_hold_r <= 1'b0;
      end else if (vsel_wr) begin
         post_hold_r <= 1'b1;
      end else if (instr_retire) begin
         post_hold_r <= 1'b0;
      end
   end

   // sequence mask; the global enable input is never written back
   logic seq_mask;
   assign seq_mask = unlock_wr || window_open || vsel_wr || post_hold_r;

   // lock bit blocking by executing section
   // the section flag comes from the core on this clock, so it is not synchronised
   logic lock_block;
   assign lock_block = (vsel_r && app_lock_s == FUSE_PROGRAMMED && !exec_in_boot)
      || (!vsel_r && boot_lock_s == FUSE_PROGRAMMED && exec_in_boot);

   ////////////////////////////////////////////////////////////////////////////
   // priority pick and vector address

   // per-source vector offset in the base table
   // offsets are constants; synthesis folds the whole table away
   logic [PC_W-1:0] vec_ofs [NUM_IRQ];
   genvar gi;
   generate
      for (gi = 0; gi < NUM_IRQ; gi++) begin : g_vec
         assign vec_ofs[gi] = FIRST_VEC + VEC_STEP * PC_W'(gi);
      end
   endgenerate

   // lowest index pending wins
   // scanning downward lets the lowest set bit overwrite every higher one
   logic pick_valid;
   logic [IRQ_W-1:0] pick_idx;
   always_comb begin
      pick_valid = 1'b0;
      pick_idx = 5'h00;
      for (int i = NUM_IRQ - 1; i >= 0; i--) begin
         if (irq_req[i]) begin
            pick_valid = 1'b1;
            pick_idx = IRQ_W'(i);
         end
      end
   end

   // table base by select bit
   // limitation: a moved table shows on the request two cycles after the write
   logic [PC_W-1:0] table_base;
   assign table_base = vsel_r ? boot_start : RESET_VEC;

   // registered request to the core
   // one cycle of latency buys a short path into the core's fetch logic
   logic irq_valid_r;
   logic [IRQ_W-1:0] irq_index_r;
   logic [PC_W-1:0] irq_vector_r;
   logic irq_masked_r;
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         irq_valid_r <= 1'b0;
         irq_index_r <= 5'h00;
         irq_vector_r <= FIRST_VEC;
         irq_masked_r <= 1'b0;
      end else begin
         irq_masked_r <= seq_mask || lock_block;
         irq_valid_r <= pick_valid && global_int_enable && !seq_mask && !lock_block;
         irq_index_r <= pick_idx;
         irq_vector_r <= table_base + vec_ofs[pick_idx];
      end
   end
   assign irq_valid = irq_valid_r;
   assign irq_index = irq_index_r;
   assign irq_vector_addr = irq_vector_r;
   assign irq_masked = irq_masked_r;

   ////////////////////////////////////////////////////////////////////////////
   // assertions
   // these watch the block's own outputs and state; the core side is the bench's job

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);

   // unlock left alone keeps the window four cycles, then shuts it
   unlock_window_a: assert property (
      (unlock_wr ##1 (!wr_hit) [*4]) |-> (window_open ##1 !window_open))
      else $error("unlock window length wrong");
   // the window opens on the edge after the unlock write
   unlock_open_a: assert property (
      unlock_wr |=> window_open)
      else $error("unlock did not open window");
   // select ignored outside the window
   vsel_guard_a: assert property (
      (wr_hit && !window_open) |=> $stable(vsel_r))
      else $error("select changed outside window");
   // an accepted select write lands in the select bit
   vsel_take_a: assert property (
      (HAS_VECTOR_SELECT && vsel_wr) |=> (vector_table_select == $past(reg_wdata[VSEL_BIT])))
      else $error("select write not taken");
   // select write closes the window at once
   vsel_close_a: assert property (
      vsel_wr |=> !window_open)
      else $error("window left open after select write");

   // no interrupt offered during the window
   seq_mask_a: assert property (
      (unlock_wr || window_open) |=> !irq_valid)
      else $error("interrupt during unlock");
   // select write and the hold after it keep interrupts off
   post_hold_a: assert property (
      (vsel_wr || post_hold_r) |=> !irq_valid)
      else $error("interrupt before the following instruction");
   // unused unlock releases the mask five cycles after the unlock write
   mask_release_a: assert property (
      ((unlock_wr && !post_hold_r) ##1 (!wr_hit && !post_hold_r) [*5]) |-> !seq_mask)
      else $error("mask not released");
   // masked flag follows the sequence mask and lock blocking
   masked_flag_a: assert property (
      (seq_mask || lock_block) |=> irq_masked)
      else $error("masked flag missing");
   // a cleared global enable gates every request
   gie_gate_a: assert property (
      !global_int_enable |=> !irq_valid)
      else $error("interrupt with global enable low");
   // lock blocking
   lock_block_a: assert property (
      lock_block |=> !irq_valid)
      else $error("locked section took interrupt");

   // reset vector follows the fuse
   reset_vec_a: assert property (
      $stable(fuse_sync_r) |->
         (reset_vector_addr == ((boot_reset_fuse_s == FUSE_PROGRAMMED) ? boot_start : RESET_VEC)))
      else $error("reset vector wrong");
   // vector address follows base and index
   vec_addr_a: assert property (
      ##1 irq_valid |-> irq_vector_addr == $past(table_base) + FIRST_VEC + VEC_STEP * PC_W'(irq_index))
      else $error("vector address wrong");
   // base table vectors stay between the first and the last slot
   vec_range_a: assert property (
      (irq_valid && !$past(vsel_r)) |-> ((irq_vector_addr >= FIRST_VEC) && (irq_vector_addr <= LAST_VEC)))
      else $error("vector outside base table");
   // lowest pending index served
   prio_a: assert property (
      irq_valid |-> (($past(irq_req) & ((25'h1 << irq_index) - 25'h1)) == 25'h0))
      else $error("priority wrong");
   // the winner was really pending
   winner_pending_a: assert property (
      irq_valid |-> ((($past(irq_req) >> irq_index) & 25'h1) == 25'h1))
      else $error("winner not pending");

   // pull-up disable takes its bit from every write
   pud_write_a: assert property (
      wr_hit |=> (pullup_global_disable == $past(reg_wdata[PUD_BIT])))
      else $error("pull-up disable not written");
   // read data carries the register image
   rd_image_a: assert property (
      rd_hit |=> (reg_rdata == {3'h0, $past(pud_r), 2'h0, $past(vsel_r), $past(window_open)}))
      else $error("read image wrong");
   // unused bits read zero
   rd_zero_a: assert property (
      reg_rd |=> (reg_rdata & ~MCU_CONTROL_RMASK) == 8'h00)
      else $error("reserved bits nonzero");
   // read data is zero outside the read cycle
   rd_idle_a: assert property (
      !reg_rd |=> (reg_rdata == 8'h00))
      else $error("read data outside read cycle");
endmodule // interrupt_vector_placement

/* File: dv/core_model.sv */
// processor core stand-in: retires instructions and owns the status flags
`timescale 1ns/100ps
module core_model (
   // clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // bench controls
   input wire logic run,
   input wire logic boot_side,
   // core status toward the block
   output logic global_int_enable,
   output logic exec_in_boot,
   output logic instr_retire
);
   logic [1:0] phase_r; // pacing of multi-cycle instructions
   ////////////////////////////////////////
   // enable flag is the core's own; the block only reads it
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         global_int_enable <= 1'b0;
         exec_in_boot <= 1'b0;
      end else begin
         global_int_enable <= 1'b1;
         exec_in_boot <= boot_side;
      end
   end
   // one retire every four cycles while running, none when halted
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         phase_r <= 2'h0;
         instr_retire <= 1'b0;
      end else begin
         phase_r <= run ? phase_r + 2'h1 : 2'h0;
         instr_retire <= run && (phase_r == 2'h3);
      end
   end
endmodule // core_model

/* File: dv/tb.sv */
// self-checking bench for the interrupt vector placement block
`timescale 1ns/100ps
module tb;
   import ivp_pkg::*;
   logic sys_clk, arst_n, reg_wr, reg_rd, boot_reset_fuse, app_lock_bit, boot_lock_bit;
   logic run, boot_side, global_int_enable, exec_in_boot, instr_retire, irq_valid, irq_masked;
   logic vector_table_select, pullup_global_disable;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata, reg_rdata;
   logic [1:0] boot_size_fuses;
   logic [NUM_IRQ-1:0] irq_req;
   logic [PC_W-1:0] reset_vector_addr, irq_vector_addr;
   logic [IRQ_W-1:0] irq_index;
   int failures = 0, comparisons = 0, cycles = 0, seed, i, sz;
   int vsel_m, bsz_m; // reference model: table select and size code
   ////////////////////////////////////////
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   interrupt_vector_placement interrupt_vector_placement_i (.sys_clk(sys_clk), .arst_n(arst_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .boot_reset_fuse(boot_reset_fuse), .boot_size_fuses(boot_size_fuses), .app_lock_bit(app_lock_bit),
      .boot_lock_bit(boot_lock_bit), .global_int_enable(global_int_enable), .exec_in_boot(exec_in_boot),
      .instr_retire(instr_retire), .irq_req(irq_req), .reset_vector_addr(reset_vector_addr),
      .irq_valid(irq_valid), .irq_index(irq_index), .irq_vector_addr(irq_vector_addr),
      .irq_masked(irq_masked), .vector_table_select(vector_table_select),
      .pullup_global_disable(pullup_global_disable));
   core_model core_model_i (.sys_clk(sys_clk), .arst_n(arst_n), .run(run), .boot_side(boot_side),
      .global_int_enable(global_int_enable), .exec_in_boot(exec_in_boot), .instr_retire(instr_retire));
   ////////////////////////////////////////
   // hang guard, far above the roughly 800 cycles the run needs
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         summarize();
      end
   end
   task automatic summarize();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic bad(input logic [PC_W-1:0] got, input logic [PC_W-1:0] exp);
      failures++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
   endtask
   task automatic chk_a(input logic [PC_W-1:0] got, input logic [PC_W-1:0] exp);
      comparisons++;
      if (got !== exp) bad(got, exp);
   endtask
   task automatic chk_d(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
      comparisons++;
      if (got !== exp) bad({6'h0, got}, {6'h0, exp});
   endtask
   task automatic chk_f(input logic got, input logic exp);
      comparisons++;
      if (got !== exp) bad({13'h0, got}, {13'h0, exp});
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   // one-cycle strobes, launched and dropped on rising edges
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 chk_d(reg_rdata, exp);
   endtask
   // unlock then select, with a one-cycle gap well inside the window
   task automatic set_sel(input int v);
      wr(MCU_CONTROL_OFS, 8'h01);
      wr(MCU_CONTROL_OFS, (v != 0) ? 8'h02 : 8'h00);
      vsel_m = v;
   endtask
   task automatic do_reset(input logic fuse, input int s);
      @(posedge sys_clk);
      arst_n <= 1'b0;
      boot_reset_fuse <= fuse;
      boot_size_fuses <= 2'(s);
      bsz_m = s;
      cyc(2);
      arst_n <= 1'b1;
      cyc(4);
      vsel_m = 0;
   endtask
   function automatic logic [PC_W-1:0] boot_start(input int s);
      case (s)
         0: return BOOT_START_SZ0;
         1: return BOOT_START_SZ1;
         2: return BOOT_START_SZ2;
         default: return BOOT_START_SZ3;
      endcase
   endfunction
   // every source, random higher requests pending beside it
   task automatic vec_scan();
      logic [NUM_IRQ-1:0] req;
      logic [PC_W-1:0] base;
      base = (vsel_m != 0) ? boot_start(bsz_m) : RESET_VEC;
      for (i = 0; i < NUM_IRQ; i++) begin
         req = NUM_IRQ'($random(seed)) << i;
         req[i] = 1'b1;
         @(posedge sys_clk);
         irq_req <= req;
         cyc(2);
         #1 chk_f(irq_valid, 1'b1);
         chk_a({9'h0, irq_index}, 14'(i));
         chk_a(irq_vector_addr, base + FIRST_VEC + VEC_STEP * 14'(i));
      end
   endtask
   ////////////////////////////////////////
   initial begin
      seed = 32'h2dbb;
      arst_n = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      boot_reset_fuse = 1'b1;
      boot_size_fuses = 2'h0;
      app_lock_bit = 1'b1;
      boot_lock_bit = 1'b1;
      run = 1'b1;
      boot_side = 1'b0;
      irq_req = '0;
      vsel_m = 0;
      bsz_m = 0;
      cyc(8);
      arst_n <= 1'b1;
      cyc(4);
      rd(MCU_CONTROL_OFS, MCU_CONTROL_RST);
      chk_a(reset_vector_addr, RESET_VEC);
      for (sz = 0; sz < 4; sz++) begin
         do_reset(1'b0, sz);
         #1 chk_a(reset_vector_addr, boot_start(sz));
         vec_scan();
         set_sel(1);
         cyc(8);
         #1 chk_f(vector_table_select, 1'b1);
         vec_scan();
      end
      // write without unlock while the select is already set; spare bits read zero
      wr(MCU_CONTROL_OFS, 8'hfc);
      rd(MCU_CONTROL_OFS, 8'h12);
      chk_f(pullup_global_disable, 1'b1);
      rd(8'h5a, 8'h00);
      @(posedge sys_clk);
      irq_req <= NUM_IRQ'(8);
      run <= 1'b0;
      cyc(3);
      #1 chk_f(irq_valid, 1'b1);
      // unlock left unused: mask and unlock bit both lapse by themselves
      wr(MCU_CONTROL_OFS, 8'h01);
      cyc(1);
      #1 chk_f(irq_valid, 1'b0);
      chk_f(irq_masked, 1'b1);
      rd(MCU_CONTROL_OFS, 8'h03);
      cyc(6);
      rd(MCU_CONTROL_OFS, 8'h02);
      chk_f(irq_valid, 1'b1);
      chk_f(irq_masked, 1'b0);
      wr(MCU_CONTROL_OFS, 8'h00);
      rd(MCU_CONTROL_OFS, 8'h02);
      // real change with the core halted: mask must outlast four cycles
      set_sel(0);
      cyc(6);
      #1 chk_f(vector_table_select, 1'b0);
      chk_f(irq_valid, 1'b0);
      @(posedge sys_clk);
      run <= 1'b1;
      cyc(8);
      #1 chk_f(irq_valid, 1'b1);
      chk_a(irq_vector_addr, FIRST_VEC + VEC_STEP * 14'h3);
      // lock blocking on each side of the table
      @(posedge sys_clk);
      boot_lock_bit <= 1'b0;
      boot_side <= 1'b1;
      cyc(6);
      #1 chk_f(irq_valid, 1'b0);
      chk_f(irq_masked, 1'b1);
      @(posedge sys_clk);
      boot_side <= 1'b0;
      cyc(6);
      #1 chk_f(irq_valid, 1'b1);
      @(posedge sys_clk);
      boot_lock_bit <= 1'b1;
      app_lock_bit <= 1'b0;
      set_sel(1);
      cyc(10);
      #1 chk_f(irq_valid, 1'b0);
      @(posedge sys_clk);
      boot_side <= 1'b1;
      cyc(6);
      #1 chk_f(irq_valid, 1'b1);
      summarize();
   end
endmodule // tb
